// ---- rtl/iobx_exec.sv ----
// I/O block transfer and control-transfer execution unit with Wishbone slave
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module iobx_exec
  import iobx_pkg::*;
(
  input  wire logic        clk_sys,      // System clock, 250 MHz
  input  wire logic        rst_b,        // Synchronous reset, active low
  input  wire logic        clkEn,        // Freezes all state while low
  input  wire logic        wbCyc,        // Wishbone cycle
  input  wire logic        wbStb,        // Wishbone strobe
  input  wire logic        wbWe,         // Wishbone write enable
  input  wire logic [7:0]  wbAdr,        // Wishbone byte address
  input  wire logic [3:0]  wbSel,        // Wishbone byte selects
  input  wire logic [31:0] wbDatI,       // Wishbone write data
  output logic      [31:0] wbDatO,       // Wishbone read data
  output logic             wbAck,        // Wishbone acknowledge
  input  wire logic        nmiReq,       // Nonmaskable request, asynchronous
  output iobx_req_s        busReq,       // Memory / I/O cycle request
  output logic             busValid,     // Bus cycle requested
  input  wire logic        busDone,      // Bus cycle complete, asynchronous
  input  wire logic [7:0]  busRdata      // Read data, valid with busDone
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WRITE, ST_PUSH_HI, ST_PUSH_LO, ST_POP_LO, ST_POP_HI
  } iobx_state_e;

  iobx_state_e state_ff;
  iobx_op_e    op_ff;
  logic [15:0] oper_ff;
  logic [15:0] pc_ff;
  logic [15:0] sp_ff;
  logic [15:0] ptr_ff;
  logic [7:0]  count_ff;
  logic [7:0]  port_ff;
  logic [7:0]  acc_ff;
  logic [7:0]  flags_ff;
  logic [15:0] idxX_ff;
  logic [15:0] idxY_ff;
  logic [7:0]  gpr_ff;
  logic [15:0] target_ff;
  logic        ien_ff;
  logic        ienSav_ff;
  logic        doneS1_ff;
  logic        doneS2_ff;
  logic        nmiS1_ff;
  logic        nmiS2_ff;
  logic        nmiPrev_ff;
  iobx_req_s   req_ff;
  logic        valid_ff;

  logic        wbHit;
  logic        wbWr;
  logic        ccTrue;
  logic        done;
  logic [15:0] disp;
  logic [15:0] relTgt;
  logic [7:0]  countDec;

  assign wbHit    = wbCyc && wbStb && !wbAck;
  assign wbWr     = wbHit && wbWe && clkEn;
  assign done     = doneS2_ff && valid_ff;
  assign disp     = {{8{oper_ff[7]}}, oper_ff[7:0]};  // [RULE24]
  assign relTgt   = pc_ff + disp;
  assign countDec = count_ff - ONE8;
  assign busReq   = req_ff;
  assign busValid = valid_ff;

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  always_comb
  begin
    case (iobx_cc_e'(wbDatI[CMD_CC_LSB +: 4]))
      CC_ALWAYS: ccTrue = 1'b1;
      CC_NZ:     ccTrue = !flags_ff[FLG_Z];
      CC_Z:      ccTrue = flags_ff[FLG_Z];
      CC_NC:     ccTrue = !flags_ff[FLG_C];
      CC_C:      ccTrue = flags_ff[FLG_C];
      CC_PO:     ccTrue = !flags_ff[FLG_PV];  // [RULE22]
      CC_PE:     ccTrue = flags_ff[FLG_PV];   // [RULE22]
      CC_P:      ccTrue = !flags_ff[FLG_S];   // [RULE22]
      CC_M:      ccTrue = flags_ff[FLG_S];    // [RULE22]
      default:   ccTrue = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      doneS1_ff  <= 1'b0;
      doneS2_ff  <= 1'b0;
      nmiS1_ff   <= 1'b0;
      nmiS2_ff   <= 1'b0;
      nmiPrev_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      doneS1_ff  <= busDone;     // [RULE20]
      doneS2_ff  <= doneS1_ff;   // [RULE20]
      nmiS1_ff   <= nmiReq;      // [RULE20]
      nmiS2_ff   <= nmiS1_ff;    // [RULE20]
      nmiPrev_ff <= nmiS2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one-cycle ack, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      wbAck <= 1'b0;
    else if (clkEn)
      wbAck <= wbHit;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      wbDatO <= 32'h0;
    else if (clkEn && wbHit)
    begin
      case (wbAdr)
        REG_CMD:  wbDatO <= {27'h0, op_ff};
        REG_OPER: wbDatO <= {16'h0, oper_ff};
        REG_PC:   wbDatO <= {16'h0, pc_ff};
        REG_SP:   wbDatO <= {16'h0, sp_ff};
        REG_PTR:  wbDatO <= {16'h0, ptr_ff};
        REG_CNTP: wbDatO <= {16'h0, count_ff, port_ff};
        REG_ACCF: wbDatO <= {16'h0, acc_ff, flags_ff};
        REG_IDX:  wbDatO <= {idxY_ff, idxX_ff};
        REG_STAT: wbDatO <= {29'h0, ienSav_ff, ien_ff, (state_ff != ST_IDLE)};
        REG_GPR:  wbDatO <= {24'h0, gpr_ff};
        default:  wbDatO <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Execution sequencer
  // ----------------------------------------------------------------
  // Software writes to architectural registers are ignored while busy, so the
  // sequencer races a bus write for the same flop only in idle, where an NMI edge's clear of ien_ff overrides a REG_STAT write.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_ff  <= ST_IDLE;
      op_ff     <= OP_NONE;
      oper_ff   <= 16'h0;
      pc_ff     <= 16'h0;
      sp_ff     <= 16'h0;
      ptr_ff    <= 16'h0;
      count_ff  <= 8'h0;
      port_ff   <= 8'h0;
      acc_ff    <= 8'h0;
      flags_ff  <= 8'h0;
      idxX_ff   <= 16'h0;
      idxY_ff   <= 16'h0;
      gpr_ff    <= 8'h0;
      target_ff <= 16'h0;
      ien_ff    <= 1'b0;
      ienSav_ff <= 1'b0;
      req_ff    <= '0;
      valid_ff  <= 1'b0;
    end
    else if (clkEn)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (wbWr && wbSel[0])
          begin
            case (wbAdr)
              REG_OPER: oper_ff  <= wbDatI[15:0];
              REG_PC:   pc_ff    <= wbDatI[15:0];
              REG_SP:   sp_ff    <= wbDatI[15:0];
              REG_PTR:  ptr_ff   <= wbDatI[15:0];
              REG_CNTP: {count_ff, port_ff} <= wbDatI[15:0];
              REG_ACCF: {acc_ff, flags_ff}  <= wbDatI[15:0];
              REG_IDX:  {idxY_ff, idxX_ff}  <= wbDatI;
              REG_STAT: ien_ff   <= wbDatI[STAT_IEN];
              REG_GPR:  gpr_ff   <= wbDatI[7:0];
              default:  ;
            endcase
          end
          if (nmiS2_ff && !nmiPrev_ff)
          begin
            ienSav_ff <= ien_ff;                  // [RULE25]
            ien_ff    <= 1'b0;
            target_ff <= oper_ff;
            op_ff     <= OP_NMI_ACCEPT;
            state_ff  <= ST_PUSH_HI;
            req_ff    <= '{isIo: 1'b0, write: 1'b1, addr: sp_ff - ONE16, data: pc_ff[15:8]};
            valid_ff  <= 1'b1;
          end
          else if (wbWr && wbAdr == REG_CMD && wbSel[3] && wbDatI[CMD_GO_BIT])
          begin
            op_ff  <= iobx_op_e'(wbDatI[CMD_OP_LSB +: 5]);
            case (iobx_op_e'(wbDatI[CMD_OP_LSB +: 5]))
              OP_IN_STEP_DOWN, OP_IN_REPEAT_DOWN:
              begin
                // Port address carries the count on the high byte
                req_ff   <= '{isIo: 1'b1, write: 1'b0, addr: {count_ff, port_ff}, data: 8'h0};
                valid_ff <= 1'b1;
                state_ff <= ST_READ;                                  // [RULE1] [RULE2]
              end
              OP_OUT_STEP_UP, OP_OUT_REPEAT_UP, OP_OUT_STEP_DOWN, OP_OUT_REPEAT_DOWN:
              begin
                req_ff   <= '{isIo: 1'b0, write: 1'b0, addr: ptr_ff, data: 8'h0};
                valid_ff <= 1'b1;
                state_ff <= ST_READ;                                  // [RULE5] [RULE7]
              end
              OP_OUT_IMM:
              begin
                req_ff   <= '{isIo: 1'b1, write: 1'b1, addr: {acc_ff, oper_ff[7:0]},
                              data: acc_ff};                          // [RULE3]
                valid_ff <= 1'b1;
                state_ff <= ST_WRITE;
              end
              OP_OUT_REG:
              begin
                req_ff   <= '{isIo: 1'b1, write: 1'b1, addr: {count_ff, port_ff},
                              data: (wbDatI[CMD_SEL_LSB +: 3] == 3'h7) ? acc_ff : gpr_ff};
                valid_ff <= 1'b1;                                     // [RULE4]
                state_ff <= ST_WRITE;
              end
              OP_ABS_JUMP:
                if (ccTrue)
                  pc_ff <= oper_ff;                                   // [RULE9]
              OP_REL_JUMP:
                // Only the unconditional form and the four carry/zero tests are legal here
                if (wbDatI[CMD_CC_LSB +: 4] <= 4'(CC_C) && ccTrue)
                  pc_ff <= relTgt;                                    // [RULE10]
              OP_IND_JUMP:
                case (wbDatI[CMD_SEL_LSB +: 3])
                  3'h1:    pc_ff <= idxX_ff;                          // [RULE11]
                  3'h2:    pc_ff <= idxY_ff;                          // [RULE11]
                  default: pc_ff <= ptr_ff;                           // [RULE11]
                endcase
              OP_LOOP_BRANCH:
              begin
                count_ff <= countDec;                                 // [RULE12]
                if (countDec != COUNT_ZERO)
                  pc_ff <= relTgt;                                    // [RULE12]
              end
              OP_CALL, OP_RESTART:
                if (ccTrue || wbDatI[CMD_OP_LSB +: 5] == 5'(OP_RESTART))
                begin
                  target_ff <= (wbDatI[CMD_OP_LSB +: 5] == 5'(OP_RESTART))
                    ? {8'h00, 8'(RESTART_STEP * wbDatI[CMD_SEL_LSB +: 3])}  // [RULE14] [RULE23]
                    : oper_ff;
                  req_ff   <= '{isIo: 1'b0, write: 1'b1, addr: sp_ff - ONE16,
                                data: pc_ff[15:8]};                   // [RULE13]
                  valid_ff <= 1'b1;
                  state_ff <= ST_PUSH_HI;
                end
              OP_RETURN, OP_IRQ_RETURN, OP_NMI_RETURN:
                if (ccTrue)                                           // [RULE16]
                begin
                  req_ff   <= '{isIo: 1'b0, write: 1'b0, addr: sp_ff, data: 8'h0};
                  valid_ff <= 1'b1;                                   // [RULE15] [RULE17]
                  state_ff <= ST_POP_LO;
                end
              default: ;
            endcase
          end
        end
        ST_READ:
          if (done)
          begin
            valid_ff <= 1'b0;
            if (op_ff == OP_IN_STEP_DOWN || op_ff == OP_IN_REPEAT_DOWN)
              req_ff <= '{isIo: 1'b0, write: 1'b1, addr: ptr_ff, data: busRdata};  // [RULE1]
            else
              req_ff <= '{isIo: 1'b1, write: 1'b1, addr: {count_ff, port_ff},
                          data: busRdata};                            // [RULE5] [RULE7]
            state_ff <= ST_WRITE;
          end
          else
            valid_ff <= !doneS2_ff;
        ST_WRITE:
          if (!valid_ff && !doneS2_ff)
            valid_ff <= 1'b1;
          else if (done)
          begin
            valid_ff <= 1'b0;
            state_ff <= ST_IDLE;
            if (op_ff != OP_OUT_IMM && op_ff != OP_OUT_REG)
            begin
              count_ff <= countDec;                                   // [RULE1] [RULE5]
              ptr_ff   <= (op_ff == OP_OUT_STEP_UP || op_ff == OP_OUT_REPEAT_UP)
                          ? ptr_ff + ONE16 : ptr_ff - ONE16;           // [RULE5] [RULE7]
              // Repeat forms return to idle after each transfer, the same as the step forms
              if ((op_ff == OP_IN_REPEAT_DOWN || op_ff == OP_OUT_REPEAT_UP ||
                   op_ff == OP_OUT_REPEAT_DOWN) && countDec != COUNT_ZERO)
                state_ff <= ST_IDLE;                                  // [RULE2] [RULE6] [RULE8]
            end
          end
        ST_PUSH_HI:
          if (done)
          begin
            valid_ff <= 1'b0;
            req_ff   <= '{isIo: 1'b0, write: 1'b1, addr: sp_ff - 16'h0002,
                          data: pc_ff[7:0]};                          // [RULE13]
            state_ff <= ST_PUSH_LO;
          end
        ST_PUSH_LO:
          if (!valid_ff && !doneS2_ff)
            valid_ff <= 1'b1;
          else if (done)
          begin
            valid_ff <= 1'b0;
            sp_ff    <= sp_ff - 16'h0002;
            pc_ff    <= target_ff;                                    // [RULE13] [RULE14]
            state_ff <= ST_IDLE;
          end
        ST_POP_LO:
          if (done)
          begin
            valid_ff <= 1'b0;
            pc_ff    <= {pc_ff[15:8], busRdata};                      // [RULE15]
            req_ff   <= '{isIo: 1'b0, write: 1'b0, addr: sp_ff + ONE16, data: 8'h0};
            state_ff <= ST_POP_HI;
          end
        ST_POP_HI:
          if (!valid_ff && !doneS2_ff)
            valid_ff <= 1'b1;
          else if (done)
          begin
            valid_ff <= 1'b0;
            pc_ff    <= {busRdata, pc_ff[7:0]};                       // [RULE15]
            sp_ff    <= sp_ff + 16'h0002;
            if (op_ff == OP_NMI_RETURN)
              ien_ff <= ienSav_ff;                                    // [RULE25] [RULE17]
            state_ff <= ST_IDLE;
          end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- rtl/iobx_pkg.sv ----
// Package for the I/O block and branch execution unit
//
// Notes on behaviour
// RULE1 - Step-in-down: read port at count/port pair, store at pointer, decrement both.
// RULE2 - Repeat-in-down: repeat the step-in-down transfer until count reaches zero. The unit does one transfer per command; software reissues it.
// RULE3 - Immediate-port output writes accumulator to port named by immediate byte.
// RULE4 - Register-port output writes selected 8-bit register to port register address.
// RULE5 - Step-out-up: memory byte at pointer to port, pointer up, count down.
// RULE6 - Repeat-out-up: repeat step-out-up until count equals zero. The unit does one transfer per command; software reissues it.
// RULE7 - Step-out-down: memory byte at pointer to port, pointer and count down.
// RULE8 - Repeat-out-down: repeat step-out-down until count equals zero. The unit does one transfer per command; software reissues it.
// RULE9 - Absolute jump loads operand; conditional form only when the condition holds.
// RULE10 - Relative jump adds displacement; conditional form tests NZ, Z, NC, C only.
// RULE11 - Indirect jump copies pointer pair or an index register to program counter.
// RULE12 - Loop branch decrements count; falls through on zero, else branches relative.
// RULE13 - Call pushes high byte at SP-1, low at SP-2, then loads target.
// RULE14 - Restart pushes like call, clears high byte, loads encoded low byte.
// RULE15 - Return pops low byte from SP and high byte from SP+1.
// RULE16 - Conditional return falls through when false, else returns normally.
// RULE17 - Maskable interrupt return pops like return; separate nonmaskable return exists.
// RULE18 - Peripherals drive the data bus only while read strobe is asserted.
// RULE19 - Interrupt vector driven only while first-cycle marker and I/O strobe asserted.
// RULE20 - All control inputs are synchronised internally before use.
// RULE21 - System holds reset asserted for at least three clock cycles.
// RULE22 - PO true on odd parity/no overflow, PE on even/overflow; P, M sign.
// RULE23 - Restart targets limited to the eight page-zero locations 0 through 56.
// RULE24 - Relative displacement is an 8-bit signed two's complement value.
// RULE25 - Nonmaskable return restores the saved maskable interrupt enable state.
package iobx_pkg;

  // Wishbone register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;  // Op, condition, register select, start
  localparam logic [7:0] REG_OPER   = 8'h04;  // 16-bit operand / displacement / port
  localparam logic [7:0] REG_PC     = 8'h08;
  localparam logic [7:0] REG_SP     = 8'h0c;
  localparam logic [7:0] REG_PTR    = 8'h10;  // Pointer pair
  localparam logic [7:0] REG_CNTP   = 8'h14;  // [15:8] count, [7:0] port register
  localparam logic [7:0] REG_ACCF   = 8'h18;  // [15:8] accumulator, [7:0] flags
  localparam logic [7:0] REG_IDX    = 8'h1c;  // [31:16] index Y, [15:0] index X
  localparam logic [7:0] REG_STAT   = 8'h20;  // Busy, enables
  localparam logic [7:0] REG_GPR    = 8'h24;  // Selectable general register value

  // Command and status register fields
  localparam int CMD_GO_BIT   = 31;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_CC_LSB   = 8;
  localparam int CMD_SEL_LSB  = 12;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_IEN     = 1;
  localparam int STAT_IENSAV  = 2;

  // Flag bit positions
  localparam int FLG_C  = 0;
  localparam int FLG_PV = 2;
  localparam int FLG_Z  = 6;
  localparam int FLG_S  = 7;

  localparam logic [7:0]  RESTART_STEP = 8'h08;  // Page-zero stride
  localparam logic [7:0]  COUNT_ZERO   = 8'h00;
  localparam logic [15:0] ONE16        = 16'h0001;
  localparam logic [7:0]  ONE8         = 8'h01;

  typedef enum logic [4:0] {
    OP_NONE, OP_IN_STEP_DOWN, OP_IN_REPEAT_DOWN, OP_OUT_IMM, OP_OUT_REG,
    OP_OUT_STEP_UP, OP_OUT_REPEAT_UP, OP_OUT_STEP_DOWN, OP_OUT_REPEAT_DOWN,
    OP_ABS_JUMP, OP_REL_JUMP, OP_IND_JUMP, OP_LOOP_BRANCH, OP_CALL,
    OP_RESTART, OP_RETURN, OP_IRQ_RETURN, OP_NMI_RETURN, OP_NMI_ACCEPT
  } iobx_op_e;

  typedef enum logic [3:0] {
    CC_ALWAYS, CC_NZ, CC_Z, CC_NC, CC_C, CC_PO, CC_PE, CC_P, CC_M
  } iobx_cc_e;

  // Bus cycle request to the memory / I/O side
  typedef struct packed {
    logic        isIo;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } iobx_req_s;

endpackage

// ---- tb/io_block_and_branch_exec_tb.sv ----
// Self-checking bench for the I/O block and branch execution unit
`timescale 1ns/100ps
`default_nettype none
module io_block_and_branch_exec_tb;
  import iobx_pkg::*;
  logic        clk_sys, rst_b, wbCyc, wbStb, wbWe, wbAck, nmiReq, busValid, busDone, slow, c;
  logic [7:0]  wbAdr, busRdata, fl, cnt, b;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [15:0] pc, sp, tgt, ptr;
  iobx_req_s   busReq;
  int          failures, compares, seed, n, k;
  iobx_op_e    blk [6] = '{OP_IN_STEP_DOWN, OP_IN_REPEAT_DOWN, OP_OUT_STEP_UP,
                           OP_OUT_REPEAT_UP, OP_OUT_STEP_DOWN, OP_OUT_REPEAT_DOWN};

  iobx_exec dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(1'b1), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .nmiReq(nmiReq), .busReq(busReq), .busValid(busValid), .busDone(busDone), .busRdata(busRdata));
  iobx_bus_model mdl_u (.clk_sys(clk_sys), .slow(slow), .busReq(busReq), .busValid(busValid),
    .busDone(busDone), .busRdata(busRdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic cond(input int cc, input logic [7:0] f);
    logic [8:0] ok;
    ok = {f[FLG_S], !f[FLG_S], f[FLG_PV], !f[FLG_PV], f[FLG_C], !f[FLG_C], f[FLG_Z], !f[FLG_Z], 1'b1};
    return ok[cc];
  endfunction
  function automatic logic [15:0] rel(input logic [15:0] p, input logic [7:0] d);
    return p + {{8{d[7]}}, d};
  endfunction
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    @(posedge clk_sys);
    while (wbAck !== 1'b1 && t < 50)
    begin
      @(posedge clk_sys);
      t++;
    end
    if (t == 50)
      failures++;
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task waitIdle;
    int t;
    t = 0;
    do
    begin
      xfer(1'b0, REG_STAT, 32'h0);
      t++;
    end
    while (rd[STAT_BUSY] !== 1'b0 && t < 100);
    if (t == 100)
      failures++;
  endtask
  task run(input iobx_op_e o, input logic [3:0] cc, input logic [2:0] sel);
    slow <= 1'($random(seed));
    xfer(1'b1, REG_CMD, (32'h1 << CMD_GO_BIT) | (32'(cc) << CMD_CC_LSB)
      | (32'(sel) << CMD_SEL_LSB) | 32'(o));
    waitIdle;
  endtask
  task setup(input logic [15:0] h, cp, af);
    xfer(1'b1, REG_PC, {16'h0, pc});
    xfer(1'b1, REG_SP, {16'h0, sp});
    xfer(1'b1, REG_PTR, {16'h0, h});
    xfer(1'b1, REG_CNTP, {16'h0, cp});
    xfer(1'b1, REG_ACCF, {16'h0, af});
    xfer(1'b1, REG_OPER, {16'h0, tgt});
  endtask
  task checkPcSp(input logic [15:0] pE, sE);
    xfer(1'b0, REG_PC, 32'h0);
    chk("pc", pE, rd[15:0]);
    xfer(1'b0, REG_SP, 32'h0);
    chk("sp", sE, rd[15:0]);
  endtask
  task roll;
    pc = 16'($random(seed));
    sp = 16'($random(seed));
    tgt = 16'($random(seed));
    ptr = 16'($random(seed));
    fl = 8'($random(seed));
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {seed, failures, compares} = {32'd25176, 64'd0};
    {rst_b, wbCyc, wbStb, wbWe, nmiReq, slow, wbAdr, wbSel, wbDatI} = {6'h0, 8'h00, 4'hf, 32'h0};
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (k = 0; k < 9; k++)
    begin
      roll;
      c = cond(k, fl);
      tgt[7:0] = (k == 0) ? 8'h80 : tgt[7:0];
      setup(ptr, 16'h0, {8'h00, fl});
      run(OP_ABS_JUMP, 4'(k), 3'h0);
      checkPcSp(c ? tgt : pc, sp);
      setup(ptr, 16'h0, {8'h00, fl});
      run(OP_REL_JUMP, 4'(k), 3'h0);
      checkPcSp((c && k < 5) ? rel(pc, tgt[7:0]) : pc, sp);
      setup(ptr, 16'h0, {8'h00, fl});
      run(OP_CALL, 4'(k), 3'h0);
      checkPcSp(c ? tgt : pc, c ? sp - 16'h2 : sp);
      if (c)
        chk("push", pc, {mdl_u.mem[sp - 16'h1], mdl_u.mem[sp - 16'h2]});
      mdl_u.mem[sp] = tgt[15:8];
      mdl_u.mem[sp + 16'h1] = tgt[7:0];
      setup(ptr, 16'h0, {8'h00, fl});
      run(OP_RETURN, 4'(k), 3'h0);
      checkPcSp(c ? {tgt[7:0], tgt[15:8]} : pc, c ? sp + 16'h2 : sp);
    end
    for (k = 0; k < 8; k++)
    begin
      roll;
      cnt = (k == 0) ? 8'h01 : (k == 1) ? 8'h00 : fl;
      setup(ptr, {cnt, fl}, {fl, fl});
      run(OP_RESTART, 4'h0, 3'(k));
      checkPcSp({8'h00, 8'(k * 8)}, sp - 16'h2);
      chk("restart push", pc, {mdl_u.mem[sp - 16'h1], mdl_u.mem[sp - 16'h2]});
      setup(ptr, {cnt, fl}, {fl, fl});
      xfer(1'b1, REG_IDX, {tgt, ~tgt});
      xfer(1'b1, REG_GPR, {24'h0, ~fl});
      run(OP_IND_JUMP, 4'h0, 3'(k));
      checkPcSp(k == 1 ? ~tgt : k == 2 ? tgt : ptr, sp);
      setup(ptr, {cnt, fl}, {fl, fl});
      run(OP_LOOP_BRANCH, 4'h0, 3'h0);
      checkPcSp(cnt == 8'h01 ? pc : rel(pc, tgt[7:0]), sp);
      xfer(1'b0, REG_CNTP, 32'h0);
      chk("loop count", {8'h00, cnt - 8'h01}, {8'h00, rd[15:8]});
      run(OP_OUT_REG, 4'h0, 3'(k));
      chk("reg port", {8'h00, k == 7 ? fl : ~fl}, {8'h00, mdl_u.portOut[fl]});
      run(OP_OUT_IMM, 4'h0, 3'h0);
      chk("imm port", {8'h00, fl}, {8'h00, mdl_u.portOut[tgt[7:0]]});
    end
    for (k = 0; k < 6; k++)
    begin
      roll;
      cnt = k[0] ? 8'h03 : fl;
      setup(ptr, {cnt, fl}, 16'h0);
      n = 0;
      do
      begin
        b = 8'($random(seed));
        mdl_u.mem[ptr] = b;
        run(blk[k], 4'h0, 3'h0);
        chk("block byte", {8'h00, k < 2 ? fl ^ 8'ha5 : b},
          {8'h00, k < 2 ? mdl_u.mem[ptr] : mdl_u.portOut[fl]});
        ptr = (k == 2 || k == 3) ? ptr + 16'h1 : ptr - 16'h1;
        cnt = cnt - 8'h01;
        n++;
      end
      while (k[0] && cnt != 8'h00 && n < 8);
      xfer(1'b0, REG_PTR, 32'h0);
      chk("pointer", ptr, rd[15:0]);
      xfer(1'b0, REG_CNTP, 32'h0);
      chk("block count", {8'h00, cnt}, {8'h00, rd[15:8]});
    end
    roll;
    mdl_u.mem[sp] = tgt[7:0];
    mdl_u.mem[sp + 16'h1] = tgt[15:8];
    setup(ptr, 16'h0, 16'h0);
    run(OP_IRQ_RETURN, 4'h0, 3'h0);
    checkPcSp(tgt, sp + 16'h2);
    xfer(1'b1, REG_STAT, 32'h1 << STAT_IEN);
    setup(ptr, 16'h0, 16'h0);
    nmiReq <= 1'b1;
    repeat (6) @(posedge clk_sys);
    nmiReq <= 1'b0;
    waitIdle;
    checkPcSp(tgt, sp - 16'h2);
    run(OP_NMI_RETURN, 4'h0, 3'h0);
    checkPcSp(pc, sp);
    xfer(1'b0, REG_STAT, 32'h0);
    chk("irq enable", 16'h1, {15'h0, rd[STAT_IEN]});
    print_verdict;
  end
endmodule
`default_nettype wire

// ---- tb/iobx_bus_model.sv ----
// Memory and I/O port model on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module iobx_bus_model
  import iobx_pkg::*;
(
  input  wire logic      clk_sys,   // System clock
  input  wire logic      slow,      // Stretch each answer
  input  wire iobx_req_s busReq,    // Cycle request
  input  wire logic      busValid,  // Request valid
  output logic           busDone,   // Cycle complete
  output logic [7:0]     busRdata   // Read data
);
  logic [7:0] mem     [0:65535];
  logic [7:0] portOut [0:255];
  logic [2:0] waitCnt;
  initial
  begin
    busDone  = 1'b0;
    busRdata = 8'h00;
    waitCnt  = 3'h0;
  end
  // Released data toggles every cycle so a late sample never sees a stale byte
  always @(posedge clk_sys)
  begin
    waitCnt <= busValid ? waitCnt + 3'h1 : 3'h0;
    if (!busValid)
      busDone <= 1'b0;
    if (!busValid)
      busRdata <= ~busRdata;
    else if (!busDone && waitCnt >= {slow, 2'h0})
    begin
      busDone <= 1'b1;
      if (busReq.write && busReq.isIo)
        portOut[busReq.addr[7:0]] <= busReq.data;
      else if (busReq.write)
        mem[busReq.addr] <= busReq.data;
      else
        busRdata <= busReq.isIo ? busReq.addr[7:0] ^ 8'ha5 : mem[busReq.addr];
    end
  end
endmodule
`default_nettype wire

// ---- tb/iobx_exec_sva.sv ----
// Checker for the execution unit's register port and bus side
`timescale 1ns/100ps
`default_nettype none
module iobx_exec_sva
  import iobx_pkg::*;
(
  input wire logic        clk_sys,   // System clock
  input wire logic        rst_b,     // Sync reset, active low
  input wire logic        clkEn,     // Clock enable
  input wire logic        wbCyc,     // Wishbone cycle
  input wire logic        wbStb,     // Wishbone strobe
  input wire logic        wbAck,     // Wishbone acknowledge
  input wire logic [31:0] wbDatO,    // Wishbone read data
  input wire iobx_req_s   busReq,    // Bus cycle request
  input wire logic        busValid,  // Bus cycle requested
  input wire logic        busDone    // Bus cycle complete
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ack_pulse;
    wbCyc && wbStb && !wbAck && clkEn |=> wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("request not acknowledged");
  property p_ack_drop;
    wbAck |=> !wbAck;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  property p_reset;
    disable iff (1'b0) !rst_b |=> !busValid && !wbAck && wbDatO == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
  property p_req_hold;
    busValid && $past(busValid) |-> $stable(busReq);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request changed");
  property p_done_sync;
    $rose(busDone) && busValid |=> busValid;
  endproperty
  a_done_sync: assert property (p_done_sync) else $error("done used unsynchronised");
  property p_done_bound;
    $rose(busDone) && busValid |-> ##[1:4] !busValid;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("request held after done");
  property p_done_blocks;
    busDone |-> !$rose(busValid);
  endproperty
  a_done_blocks: assert property (p_done_blocks) else $error("new request over done");
  property p_in_store;
    $fell(busValid) && $past(busReq.isIo) && !$past(busReq.write)
      |-> ##[1:12] (busValid && busReq.write && !busReq.isIo);
  endproperty
  a_in_store: assert property (p_in_store) else $error("port byte not stored");
endmodule
bind iobx_exec iobx_exec_sva chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .wbDatO(wbDatO), .busReq(busReq),
  .busValid(busValid), .busDone(busDone));
`default_nettype wire
